// file: src/drs_pkg.sv
// Purpose: shared constants for the drive reference shaping block
// Assumes: speeds in rpm, torques in tenths of a percent
// Notes: selector codes are the operator-visible values
package drs_pkg;
  localparam int SPD_W = 16;
  localparam int TRQ_W = 16;
  localparam int SKIP_N = 3;
  localparam logic [15:0] SPEED_SET_MAX = 16'hEA60;
  localparam logic [15:0] HALF_WIDTH_MAX = 16'h02EE;
  localparam logic [15:0] HALF_WIDTH_RST = 16'h0000;
  localparam logic [15:0] SKIP_ONE_RST = 16'h0258;
  localparam logic [15:0] SKIP_TWO_RST = 16'h0384;
  localparam logic [15:0] SKIP_THREE_RST = 16'h04B0;
  localparam logic [15:0] JOG_RST = 16'h0096;
  localparam logic signed [15:0] TRQ_POS_MAX = 16'sh0FA0;
  localparam logic signed [15:0] TRQ_NEG_MAX = -16'sh0FA0;
  localparam logic signed [15:0] PANEL_TRQ_RST = 16'sh0000;
  localparam logic signed [15:0] TRQ_UPPER_RST = 16'sh0FA0;
  localparam logic signed [15:0] TRQ_LOWER_RST = 16'sh0000;
  localparam logic [2:0] CTRL_TYPE_VECTOR_ENC = 3'h2;
  localparam logic [1:0] CTRL_MODE_TORQUE = 2'h1;
  localparam logic [1:0] SRC_PANEL = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] SRC_FREQ = 2'h2;
  localparam logic [4:0] AI_SEL_MAX = 5'h1E;
  localparam logic [4:0] AI_SLOT_BASE = 5'h03;
  localparam logic [1:0] AI_UNUSED_POS = 2'h3;
  localparam int AI_CODES = 31;
  localparam logic [1:0] FI_OFF = 2'h0;
  localparam logic [1:0] FI_FIVE = 2'h1;
  localparam logic [1:0] FI_SIX = 2'h2;
  localparam int CLK_MHZ = 25;
  localparam int CTRL_PERIOD_NS = 1000;
  localparam int CTRL_CYCLES = (CTRL_PERIOD_NS * CLK_MHZ + 999) / 1000;
endpackage

// file: src/drs_reference_shaping.sv
// Purpose: speed and torque reference conditioning for a motor drive
// Assumes: all inputs come from logic on clk; settings load on cfg_load
// Notes: speed and torque references update once per control cycle (ctrl_tick); selectors update on load only while motor_stopped
`timescale 1ns/1ns
module drs_reference_shaping
  import drs_pkg::*;
#(
  parameter int CYCLE_CLKS = CTRL_CYCLES
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_load,
  input wire logic motor_stopped,
  input wire logic [SPD_W-1:0] cfg_skip_one,
  input wire logic [SPD_W-1:0] cfg_skip_two,
  input wire logic [SPD_W-1:0] cfg_skip_three,
  input wire logic [SPD_W-1:0] cfg_half_width,
  input wire logic [SPD_W-1:0] cfg_jog_ref,
  input wire logic signed [TRQ_W-1:0] cfg_panel_torque,
  input wire logic [TRQ_W-1:0] cfg_torque_upper,
  input wire logic [TRQ_W-1:0] cfg_torque_lower,
  input wire logic [1:0] cfg_torque_source,
  input wire logic [4:0] cfg_torque_analog,
  input wire logic [1:0] cfg_torque_freq,
  input wire logic [2:0] control_type_sel,
  input wire logic [1:0] control_mode_sel,
  input wire logic [SPD_W-1:0] speed_min,
  input wire logic [SPD_W-1:0] speed_max,
  input wire logic [SPD_W-1:0] accel_step,
  input wire logic run_cmd,
  input wire logic jog_cmd,
  input wire logic [SPD_W-1:0] speed_ref_in,
  input wire logic [AI_CODES*TRQ_W-1:0] analog_in,
  input wire logic signed [TRQ_W-1:0] freq_input_five,
  input wire logic signed [TRQ_W-1:0] freq_input_six,
  output logic ctrl_tick,
  output logic [SPD_W-1:0] speed_ref_q,
  output logic signed [TRQ_W-1:0] torque_ref_q,
  output logic torque_active_q,
  output logic [1:0] torque_source_sel,
  output logic [4:0] torque_analog_sel,
  output logic [1:0] torque_freq_sel
);
  logic [SPD_W-1:0] skip_one_q;
  logic [SPD_W-1:0] skip_two_q;
  logic [SPD_W-1:0] skip_speed_third;
  logic [SPD_W-1:0] skip_half_width;
  logic [SPD_W-1:0] jog_speed_ref;
  logic signed [TRQ_W-1:0] panel_torque_ref;
  logic signed [TRQ_W-1:0] torque_upper_limit;
  logic signed [TRQ_W-1:0] torque_lower_limit;
  logic [15:0] div_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // control cycle enable
  assign ctrl_tick = (div_q == 16'(CYCLE_CLKS - 1));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      div_q <= 16'h0000;
    else if (ctrl_tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  // settings: out-of-range speeds and torques saturate on load
  wire logic [SPD_W-1:0] ld_one = (cfg_skip_one > SPEED_SET_MAX) ? SPEED_SET_MAX : cfg_skip_one;
  wire logic [SPD_W-1:0] ld_two = (cfg_skip_two > SPEED_SET_MAX) ? SPEED_SET_MAX : cfg_skip_two;
  wire logic [SPD_W-1:0] ld_three = (cfg_skip_three > SPEED_SET_MAX) ? SPEED_SET_MAX : cfg_skip_three;
  wire logic [SPD_W-1:0] ld_half = (cfg_half_width > HALF_WIDTH_MAX) ? HALF_WIDTH_MAX : cfg_half_width;
  wire logic [SPD_W-1:0] ld_jog = (cfg_jog_ref > SPEED_SET_MAX) ? SPEED_SET_MAX : cfg_jog_ref;
  wire logic signed [TRQ_W-1:0] ld_panel = (cfg_panel_torque > TRQ_POS_MAX) ? TRQ_POS_MAX :
                                         (cfg_panel_torque < TRQ_NEG_MAX) ? TRQ_NEG_MAX : cfg_panel_torque;
  wire logic signed [TRQ_W-1:0] ld_upper = (cfg_torque_upper > TRQ_POS_MAX) ? TRQ_POS_MAX : cfg_torque_upper;
  wire logic signed [TRQ_W-1:0] ld_lower = (cfg_torque_lower > TRQ_POS_MAX) ? TRQ_POS_MAX : cfg_torque_lower;
  // selectors only move while stopped; an illegal code is dropped
  wire logic sel_load = cfg_load && motor_stopped;
  wire logic src_ok = (cfg_torque_source <= SRC_FREQ);
  wire logic ai_ok = (cfg_torque_analog <= AI_SEL_MAX);
  wire logic fi_ok = (cfg_torque_freq <= FI_SIX);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      skip_one_q <= SKIP_ONE_RST;
      skip_two_q <= SKIP_TWO_RST;
      skip_speed_third <= SKIP_THREE_RST;
      skip_half_width <= HALF_WIDTH_RST;
      jog_speed_ref <= JOG_RST;
      panel_torque_ref <= PANEL_TRQ_RST;
      torque_upper_limit <= TRQ_UPPER_RST;
      torque_lower_limit <= TRQ_LOWER_RST;
    end
    else if (cfg_load)
    begin
      skip_one_q <= ld_one;
      skip_two_q <= ld_two;
      skip_speed_third <= ld_three;
      skip_half_width <= ld_half;
      jog_speed_ref <= ld_jog;
      panel_torque_ref <= ld_panel;
      torque_upper_limit <= ld_upper;
      torque_lower_limit <= ld_lower;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      torque_source_sel <= SRC_PANEL;
      torque_analog_sel <= 5'h00;
      torque_freq_sel <= FI_OFF;
    end
    else if (sel_load)
    begin
      if (src_ok)
        torque_source_sel <= cfg_torque_source;
      if (ai_ok)
        torque_analog_sel <= cfg_torque_analog;
      if (fi_ok)
        torque_freq_sel <= cfg_torque_freq;
    end
  end

  // analog code decode: fourth position of each slot is unused
  wire logic [4:0] ai_rel = torque_analog_sel - AI_SLOT_BASE;
  wire logic ai_valid = (torque_analog_sel != 5'h00) &&
                        ((torque_analog_sel < AI_SLOT_BASE) || (ai_rel[1:0] != AI_UNUSED_POS));
  wire logic signed [TRQ_W-1:0] ai_value = ai_valid ? analog_in[torque_analog_sel * TRQ_W +: TRQ_W] : '0;
  wire logic signed [TRQ_W-1:0] fi_value = (torque_freq_sel == FI_FIVE) ? freq_input_five :
                                           (torque_freq_sel == FI_SIX) ? freq_input_six : '0;
  wire logic signed [TRQ_W-1:0] trq_sel = (torque_source_sel == SRC_ANALOG) ? ai_value :
                                          (torque_source_sel == SRC_FREQ) ? fi_value : panel_torque_ref;
  // upper limit is applied last so it wins if the limits cross
  wire logic signed [TRQ_W-1:0] trq_lo = (trq_sel < torque_lower_limit) ? torque_lower_limit : trq_sel;
  wire logic signed [TRQ_W-1:0] trq_clamped = (trq_lo > torque_upper_limit) ? torque_upper_limit : trq_lo;
  wire logic trq_mode_ok = (control_type_sel == CTRL_TYPE_VECTOR_ENC) &&
                           (control_mode_sel == CTRL_MODE_TORQUE);

  // speed target: run owns the reference, jog only while run is low
  wire logic jog_active = jog_cmd && !run_cmd;
  wire logic [SPD_W-1:0] target_sel = run_cmd ? speed_ref_in : (jog_active ? jog_speed_ref : '0);
  logic [SPD_W-1:0] target_skip;

  drs_skip_band u_skip (
    .skip_speed({skip_speed_third, skip_two_q, skip_one_q}),
    .half_width(skip_half_width),
    .speed_min(speed_min),
    .speed_max(speed_max),
    .ref_in(target_sel),
    .ref_out(target_skip)
  );

  // ramp: a zero step would freeze the output, so it moves at least 1 rpm
  wire logic [SPD_W-1:0] step = (accel_step == '0) ? 16'h0001 : accel_step;
  wire logic [SPD_W-1:0] gap_up = target_skip - speed_ref_q;
  wire logic [SPD_W-1:0] gap_dn = speed_ref_q - target_skip;
  wire logic [SPD_W-1:0] speed_d = (target_skip > speed_ref_q) ? ((gap_up > step) ? speed_ref_q + step : target_skip) :
                                   ((gap_dn > step) ? speed_ref_q - step : target_skip);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      speed_ref_q <= 16'h0000;
      torque_ref_q <= 16'sh0000;
      torque_active_q <= 1'b0;
    end
    else if (ctrl_tick)
    begin
      speed_ref_q <= speed_d;
      torque_ref_q <= trq_mode_ok ? trq_clamped : 16'sh0000;
      torque_active_q <= trq_mode_ok;
    end
  end

  wire logic [SPD_W-1:0] ramp_move = (speed_d > speed_ref_q) ? speed_d - speed_ref_q : speed_ref_q - speed_d;

  a_half_width_max: assert property (skip_half_width <= HALF_WIDTH_MAX)
    else $error("skip half-width above range");
  a_skip_third_range: assert property (skip_speed_third <= SPEED_SET_MAX)
    else $error("third skip speed above range");
  a_skip_bypass: assert property ((skip_half_width == '0) |-> target_skip == target_sel)
    else $error("skip applied with zero half-width");
  a_jog_run_block: assert property (run_cmd |-> target_sel == speed_ref_in)
    else $error("jog acted while run asserted");
  a_jog_target: assert property ((jog_cmd && !run_cmd) |-> target_sel == jog_speed_ref)
    else $error("jog target not used");
  a_ramp_bounded: assert property (ctrl_tick |-> ramp_move <= step)
    else $error("speed moved faster than ramp");
  a_cycle_hold: assert property (!ctrl_tick |=> $stable(speed_ref_q) && $stable(torque_ref_q))
    else $error("outputs changed outside control cycle");
  a_torque_gated: assert property ((ctrl_tick && !trq_mode_ok)
    |=> torque_ref_q == 16'sh0000 && !torque_active_q)
    else $error("torque applied outside torque mode");
  a_panel_range: assert property (panel_torque_ref <= TRQ_POS_MAX && panel_torque_ref >= TRQ_NEG_MAX)
    else $error("panel torque out of range");
  a_torque_upper: assert property (ctrl_tick |=> torque_ref_q <= $past(torque_upper_limit))
    else $error("torque above maximum");
  a_torque_lower: assert property ((ctrl_tick && trq_mode_ok && torque_lower_limit <= torque_upper_limit)
    |=> torque_ref_q >= $past(torque_lower_limit))
    else $error("torque below minimum");
  a_source_locked: assert property (!motor_stopped |=> $stable(torque_source_sel))
    else $error("torque source changed while running");
  a_analog_locked: assert property (!motor_stopped |=> $stable(torque_analog_sel))
    else $error("analog selector changed while running");
  a_freq_locked: assert property (!motor_stopped |=> $stable(torque_freq_sel))
    else $error("frequency selector changed while running");
endmodule

// file: src/drs_skip_band.sv
// Purpose: skip band substitution on a speed reference
// Assumes: combinational, evaluated inside the owner's control cycle
// Notes: two merge passes are enough to chain three bands
`timescale 1ns/1ns
module drs_skip_band
  import drs_pkg::*;
(
  input wire logic [SKIP_N-1:0][SPD_W-1:0] skip_speed,
  input wire logic [SPD_W-1:0] half_width,
  input wire logic [SPD_W-1:0] speed_min,
  input wire logic [SPD_W-1:0] speed_max,
  input wire logic [SPD_W-1:0] ref_in,
  output logic [SPD_W-1:0] ref_out
);
  logic [SKIP_N-1:0][SPD_W-1:0] band_lo;
  logic [SKIP_N-1:0][SPD_W-1:0] band_hi;
  logic hit;
  logic [SPD_W-1:0] m_lo;
  logic [SPD_W-1:0] m_hi;

  for (genvar i = 0; i < SKIP_N; i++)
  begin : g_band
    wire logic [SPD_W:0] raw_hi = {1'b0, skip_speed[i]} + {1'b0, half_width};
    wire logic [SPD_W-1:0] raw_lo = (skip_speed[i] < half_width) ? '0 : skip_speed[i] - half_width;
    assign band_lo[i] = (raw_lo < speed_min) ? speed_min : raw_lo;
    assign band_hi[i] = (raw_hi > {1'b0, speed_max}) ? speed_max : raw_hi[SPD_W-1:0];
  end

  always_comb
  begin
    hit = 1'b0;
    m_lo = ref_in;
    m_hi = ref_in;
    for (int i = 0; i < SKIP_N; i++)
    begin
      if (!hit && ref_in >= band_lo[i] && ref_in <= band_hi[i])
      begin
        hit = 1'b1;
        m_lo = band_lo[i];
        m_hi = band_hi[i];
      end
    end
    // grow the hit band by every band that touches it
    for (int p = 0; p < SKIP_N - 1; p++)
    begin
      for (int j = 0; j < SKIP_N; j++)
      begin
        if (hit && band_lo[j] <= m_hi && band_hi[j] >= m_lo)
        begin
          if (band_lo[j] < m_lo)
            m_lo = band_lo[j];
          if (band_hi[j] > m_hi)
            m_hi = band_hi[j];
        end
      end
    end
  end

  assign ref_out = (half_width == '0) ? ref_in : (hit ? m_lo : ref_in);
endmodule

// file: testbench/drs_ctrl_model.sv
// Purpose: downstream speed and torque controller model for the shaping block
// Assumes: references are valid from the edge after ctrl_tick
// Notes: takes a fresh reference only once per control cycle, as a real loop would
`timescale 1ns/1ns
module drs_ctrl_model
  import drs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctrl_tick,
  input wire logic [SPD_W-1:0] speed_ref_q,
  input wire logic signed [TRQ_W-1:0] torque_ref_q,
  output logic [SPD_W-1:0] ctl_speed,
  output logic signed [TRQ_W-1:0] ctl_torque
);
  logic tick_seen;
  // sample one edge late so the registered reference has settled
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_seen <= 1'b0;
      ctl_speed <= 16'h0000;
      ctl_torque <= 16'sh0000;
    end
    else
    begin
      tick_seen <= ctrl_tick;
      if (tick_seen)
      begin
        ctl_speed <= speed_ref_q;
        ctl_torque <= torque_ref_q;
      end
    end
  end
endmodule

// file: testbench/test_drive_reference_shaping.sv
// Purpose: self-checking bench for drs_reference_shaping
// Assumes: CYCLE_CLKS of 4 keeps control cycles short
// Notes: torque from a network master goes through the panel source and value
`timescale 1ns/1ns
module test_drive_reference_shaping
  import drs_pkg::*;
;
  typedef struct {
    logic [1:0] src; logic signed [15:0] pan; logic [4:0] ai; logic [1:0] fi; logic [2:0] typ; logic [1:0] mod;
    logic [15:0] up, lo, exp_t, hw, smin; logic run, jog; logic [15:0] ref_v, exp_s;
  } drs_row_s;
  drs_row_s rows [0:10] = '{
    '{2'h0, 16'h01F4, 5'h00, 2'h0, 3'h2, 2'h1, 16'h0FA0, 16'h0000, 16'h01F4,
      16'h0000, 16'h0000, 1'h1, 1'h0, 16'h03E8, 16'h03E8},
    '{2'h0, 16'h01F4, 5'h00, 2'h0, 3'h1, 2'h1, 16'h0FA0, 16'h0000, 16'h0000,
      16'h0064, 16'h0000, 1'h1, 1'h0, 16'h03E8, 16'h0320},
    '{2'h0, 16'h01F4, 5'h00, 2'h0, 3'h2, 2'h0, 16'h0FA0, 16'h0000, 16'h0000,
      16'h00C8, 16'h0000, 1'h1, 1'h0, 16'h0514, 16'h0190},
    '{2'h0, 16'h0BB8, 5'h00, 2'h0, 3'h2, 2'h1, 16'h07D0, 16'h0000, 16'h07D0,
      16'h00C8, 16'h01C2, 1'h1, 1'h0, 16'h0514, 16'h01C2},
    '{2'h0, 16'hFED4, 5'h00, 2'h0, 3'h2, 2'h1, 16'h0FA0, 16'h0064, 16'h0064,
      16'h0064, 16'h0000, 1'h0, 1'h1, 16'h03E8, 16'h0096},
    '{2'h1, 16'h0000, 5'h11, 2'h0, 3'h2, 2'h1, 16'h0FA0, 16'h0000, 16'h06A4,
      16'h0064, 16'h0000, 1'h1, 1'h1, 16'h04E2, 16'h044C},
    '{2'h1, 16'h0000, 5'h01, 2'h0, 3'h2, 2'h1, 16'h0FA0, 16'h0000, 16'h0064,
      16'h0064, 16'h0000, 1'h0, 1'h0, 16'h04E2, 16'h0000},
    '{2'h1, 16'h0000, 5'h06, 2'h0, 3'h2, 2'h1, 16'h0FA0, 16'h0000, 16'h0000,
      16'h0064, 16'h0000, 1'h1, 1'h0, 16'h02BC, 16'h01F4},
    '{2'h2, 16'h0000, 5'h00, 2'h1, 3'h2, 2'h1, 16'h0FA0, 16'h0000, 16'h05DC,
      16'h0000, 16'h0000, 1'h1, 1'h0, 16'h0384, 16'h0384},
    '{2'h2, 16'h0000, 5'h00, 2'h2, 3'h2, 2'h1, 16'h0FA0, 16'h0000, 16'h00FA,
      16'h0064, 16'h0000, 1'h1, 1'h0, 16'h0515, 16'h0515},
    '{2'h2, 16'h0000, 5'h00, 2'h0, 3'h2, 2'h1, 16'h0FA0, 16'h0000, 16'h0000,
      16'h0064, 16'h0000, 1'h1, 1'h0, 16'h0515, 16'h0515}};
  logic clk = 0, arst_n = 0, cfg_load = 0, motor_stopped = 1, run_cmd = 0, jog_cmd = 0;
  logic [15:0] hw = 0, jog_ref = 16'h0096, up = 16'h0FA0, lo = 0, smin = 0, step = 16'hEA60, ref_v = 0, e;
  logic signed [15:0] pan = 0;
  logic [15:0] skip3 = 16'h04B0, smax = 16'hEA60;
  logic [1:0] src = 0, fi = 0, mod = 0;
  logic [4:0] ai = 0;
  logic [2:0] typ = 0;
  logic [AI_CODES*TRQ_W-1:0] analog_in;
  logic ctrl_tick, torque_active_q;
  logic [15:0] speed_ref_q, ctl_speed;
  logic signed [15:0] torque_ref_q, ctl_torque;
  logic [1:0] torque_source_sel, torque_freq_sel;
  logic [4:0] torque_analog_sel;
  int n_errors = 0, comparisons = 0, cycles = 0;
  always #20 clk = ~clk;
  drs_reference_shaping #(.CYCLE_CLKS(4)) DUT (.clk(clk), .arst_n(arst_n), .cfg_load(cfg_load),
    .motor_stopped(motor_stopped), .cfg_skip_one(16'h0258), .cfg_skip_two(16'h0384), .cfg_skip_three(skip3),
    .cfg_half_width(hw), .cfg_jog_ref(jog_ref), .cfg_panel_torque(pan), .cfg_torque_upper(up), .cfg_torque_lower(lo),
    .cfg_torque_source(src), .cfg_torque_analog(ai), .cfg_torque_freq(fi), .control_type_sel(typ),
    .control_mode_sel(mod), .speed_min(smin), .speed_max(smax), .accel_step(step), .run_cmd(run_cmd),
    .jog_cmd(jog_cmd), .speed_ref_in(ref_v), .analog_in(analog_in), .freq_input_five(16'sh05DC),
    .freq_input_six(16'sh00FA), .ctrl_tick(ctrl_tick), .speed_ref_q(speed_ref_q), .torque_ref_q(torque_ref_q),
    .torque_active_q(torque_active_q), .torque_source_sel(torque_source_sel),
    .torque_analog_sel(torque_analog_sel), .torque_freq_sel(torque_freq_sel));
  drs_ctrl_model partner (.clk(clk), .arst_n(arst_n), .ctrl_tick(ctrl_tick), .speed_ref_q(speed_ref_q),
    .torque_ref_q(torque_ref_q), .ctl_speed(ctl_speed), .ctl_torque(ctl_torque));
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic load();
    @(negedge clk) cfg_load = 1;
    @(negedge clk) cfg_load = 0;
  endtask
  // returns at the falling edge after the update edge
  task automatic next_tick();
    int n;
    n = 0;
    @(negedge clk);
    while (ctrl_tick !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    for (int c = 0; c < AI_CODES; c++)
      analog_in[c*16 +: 16] = 16'(c * 100);
    repeat (12) @(negedge clk);
    chk16(speed_ref_q, 16'h0000);
    chk_bit(torque_active_q, 1'b0);
    chk16({14'h0000, torque_source_sel}, 16'h0000);
    arst_n = 1;
    jog_cmd = 1;
    next_tick();
    chk16(speed_ref_q, 16'h0096);
    run_cmd = 1;
    ref_v = 16'h04B0;
    next_tick();
    chk16(speed_ref_q, 16'h04B0);
    foreach (rows[i])
    begin
      src = rows[i].src;
      pan = rows[i].pan;
      ai = rows[i].ai;
      fi = rows[i].fi;
      typ = rows[i].typ;
      mod = rows[i].mod;
      up = rows[i].up;
      lo = rows[i].lo;
      hw = rows[i].hw;
      smin = rows[i].smin;
      run_cmd = rows[i].run;
      jog_cmd = rows[i].jog;
      ref_v = rows[i].ref_v;
      load();
      next_tick();
      chk16(torque_ref_q, rows[i].exp_t);
      chk_bit(torque_active_q, typ == CTRL_TYPE_VECTOR_ENC && mod == CTRL_MODE_TORQUE);
      chk16(speed_ref_q, rows[i].exp_s);
      chk16({9'h000, torque_analog_sel, torque_source_sel}, {9'h000, ai, src});
    end
    motor_stopped = 0;
    src = SRC_PANEL;
    fi = FI_FIVE;
    load();
    chk16({14'h0000, torque_source_sel}, 16'h0002);
    chk16({14'h0000, torque_freq_sel}, 16'h0000);
    motor_stopped = 1;
    src = 2'h3;
    ai = 5'h1F;
    load();
    chk16({9'h000, torque_analog_sel, torque_source_sel}, 16'h0002);
    chk16({14'h0000, torque_freq_sel}, 16'h0001);
    // ramp down from 1301 to a jog target of 350 in steps of 100
    run_cmd = 0;
    jog_cmd = 1;
    jog_ref = 16'h015E;
    step = 16'h0064;
    load();
    e = 16'h0515;
    repeat (11)
    begin
      next_tick();
      e = (e > 16'h01C2) ? e - 16'h0064 : 16'h015E;
      chk16(speed_ref_q, e);
    end
    @(negedge clk);
    chk16(ctl_speed, 16'h015E);
    chk16(ctl_torque, 16'h05DC);
    // out-of-range third skip speed and half-width must saturate on load
    skip3 = 16'hFFFF;
    hw = 16'hFFFF;
    step = 16'hEA60;
    run_cmd = 1;
    ref_v = 16'hEA2E;
    load();
    next_tick();
    chk16(speed_ref_q, 16'hE772);
    // band top saturated at the maximum reference leaves the target outside
    smax = 16'hEA10;
    next_tick();
    chk16(speed_ref_q, 16'hEA2E);
    chk_bit(ctrl_tick, 1'b0);
    repeat (3) @(negedge clk);
    chk_bit(ctrl_tick, 1'b1);
    arst_n = 0;
    #1;
    chk16(speed_ref_q, 16'h0000);
    chk16({14'h0000, torque_source_sel}, 16'h0000);
    wrap_up();
  end
endmodule
